// File: rtl/sdc_cfg.svh
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define SDC_RESULT_W 16
`define SDC_CNT_W 11
`define SDC_SCALE_W 27

// ----------------------------------------------------------------------
// Channel codes
// ----------------------------------------------------------------------
`define SDC_CHAN_LAST_EXT 3'h4
`define SDC_CHAN_SUPPLY 3'h5
`define SDC_CHAN_TEMP 3'h6
`define SDC_CHAN_SHORT 3'h7

// ----------------------------------------------------------------------
// Gain, oversampling and buffer codes
// ----------------------------------------------------------------------
`define SDC_GAIN_MAX 3'h5
`define SDC_OSR_MAX_CODE 3'h5
`define SDC_OSR_MIN 11'h020
`define SDC_SCALE_BASE 4'hb
`define SDC_BUF_OFF 2'h0
`define SDC_BUF_LOW 2'h1
`define SDC_BUF_MED 2'h2
`define SDC_BUF_HIGH 2'h3

// ----------------------------------------------------------------------
// Interrupt delay: conversions withheld after a start condition
// ----------------------------------------------------------------------
`define SDC_DLY_SKIP_00 2'h3
`define SDC_DLY_SKIP_01 2'h2
`define SDC_DLY_SKIP_10 2'h1
`define SDC_DLY_SKIP_11 2'h0
`define SDC_CONV_CNT_MAX 2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SDC_RST_CHAN 3'h0
`define SDC_RST_GAIN 3'h0
`define SDC_RST_RESULT 16'h0000
`define SDC_RST_PINS 8'h00

`endif

// File: rtl/sdc_pkg.sv
`include "sdc_cfg.svh"

package sdc_pkg;

  typedef enum logic {SDC_IDLE, SDC_RUN} sdc_state_e;

  typedef enum logic [1:0] {SDC_SRC_EXT, SDC_SRC_SUPPLY, SDC_SRC_TEMP, SDC_SRC_SHORT} sdc_src_e;

  typedef logic [`SDC_RESULT_W-1:0] sdc_result_t;
  typedef logic [`SDC_CNT_W-1:0] sdc_count_t;

  // Codes above the largest ratio behave as the largest ratio.
  function automatic logic [2:0] sdc_osr_code(input logic [2:0] sel);
    sdc_osr_code = (sel > `SDC_OSR_MAX_CODE) ? `SDC_OSR_MAX_CODE : sel;
  endfunction : sdc_osr_code

endpackage : sdc_pkg

// File: rtl/sdc_decim.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdc_cfg.svh"

module sdc_decim import sdc_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Control
  input wire logic run,
  input wire logic [2:0] osr_sel,
  // Bit stream in, decimated count out
  input wire logic bit_in,
  output sdc_count_t ones_ff,
  output logic done_ff
);

  sdc_count_t samp_ff, nxt_samp;
  sdc_count_t acc_ff, nxt_acc;
  sdc_count_t nxt_ones;
  logic nxt_done;
  sdc_count_t osr;

  // ----------------------------------------------------------------------
  // Averaging of the one-bit stream over one oversampling window
  // ----------------------------------------------------------------------
  always_comb begin
    osr = `SDC_OSR_MIN << sdc_osr_code(osr_sel);
    nxt_samp = samp_ff;
    nxt_acc = acc_ff;
    nxt_ones = ones_ff;
    nxt_done = 1'b0;
    if (!run) begin
      nxt_samp = '0;
      nxt_acc = '0;
    end else if (samp_ff == osr - 11'h001) begin
      nxt_ones = acc_ff + {10'h000, bit_in};
      nxt_acc = '0;
      nxt_samp = '0;
      nxt_done = 1'b1;
    end else begin
      nxt_samp = samp_ff + 11'h001;
      nxt_acc = acc_ff + {10'h000, bit_in};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      samp_ff <= '0;
      acc_ff <= '0;
      ones_ff <= '0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      samp_ff <= nxt_samp;
      acc_ff <= nxt_acc;
      ones_ff <= nxt_ones;
      done_ff <= nxt_done;
    end
  end

endmodule : sdc_decim

`default_nettype wire

// File: rtl/sdc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdc_cfg.svh"

// Overview of operation
// - Modulator bit stream averaged into each result
// - Results delivered sixteen bits wide
// - Selectable oversampling ratio, largest 1024
// - Reference generator follows only its enable
// - Buffer bit drives reference onto pin
// - External reference only when both bits clear
// - Converter powered only while converting
// - Reference stays on across converter power-down
// - Channel field picks one of eight pairs
// - Pairs 0-4 pins, 5 supply, 6 temp, 7 short
// - Six gains from 1 to 32
// - Analog enable disconnects digital pin circuitry
// - Channel/gain changes apply at next decimation, at once when idle
// - Delay 00 withholds requests until fourth conversion
// - Buffer field decodes off, low, medium, high
// - Done flag set on result, cleared by read
// - Single mode stops after first unwithheld result, clears start bit
module sdc_ctrl import sdc_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Configuration levels
  input wire logic reference_enable,
  input wire logic reference_output_buffer_enable,
  input wire logic [2:0] input_channel_select,
  input wire logic [2:0] gain_select,
  input wire logic [7:0] analog_pin_enable,
  input wire logic [1:0] interrupt_delay,
  input wire logic [1:0] buffer_speed_select,
  input wire logic [2:0] osr_select,
  input wire logic single_mode,
  // Software strobes
  input wire logic start_set,
  input wire logic start_clear,
  input wire logic chan_gain_write,
  input wire logic result_read,
  input wire logic flag_clear,
  // Modulator bit stream
  input wire logic mod_bit,
  // Reference and analog front end
  output logic ref_gen_on_ff,
  output logic ref_pin_drive_oe_ff,
  output logic ext_ref_accept_ff,
  output logic [7:0] digital_disconnect_ff,
  output logic buf_low_ff,
  output logic buf_med_ff,
  output logic buf_high_ff,
  output logic converter_power_on,
  output sdc_src_e applied_src_ff,
  output logic [2:0] applied_chan_ff,
  output logic [2:0] applied_gain_ff,
  // Conversion status
  output logic start_conversion_bit,
  output logic conversion_done_flag,
  output sdc_result_t result_register,
  output logic conv_irq_ff
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic sdc_src_e chan_src(input logic [2:0] ch);
    unique case (ch)
      `SDC_CHAN_SUPPLY: chan_src = SDC_SRC_SUPPLY;
      `SDC_CHAN_TEMP: chan_src = SDC_SRC_TEMP;
      `SDC_CHAN_SHORT: chan_src = SDC_SRC_SHORT;
      default: chan_src = SDC_SRC_EXT;
    endcase
  endfunction : chan_src

  function automatic logic [1:0] delay_skip(input logic [1:0] d);
    unique case (d)
      2'h0: delay_skip = `SDC_DLY_SKIP_00;
      2'h1: delay_skip = `SDC_DLY_SKIP_01;
      2'h2: delay_skip = `SDC_DLY_SKIP_10;
      2'h3: delay_skip = `SDC_DLY_SKIP_11;
    endcase
  endfunction : delay_skip

  // A full-scale count saturates; otherwise the count is left aligned.
  function automatic sdc_result_t scale(input sdc_count_t ones, input logic [2:0] sel);
    logic [`SDC_SCALE_W-1:0] wide;
    logic [3:0] sh;
    wide = '0;
    sh = `SDC_SCALE_BASE - {1'b0, sdc_osr_code(sel)};
    wide = {16'h0000, ones} << sh;
    if (ones == (`SDC_OSR_MIN << sdc_osr_code(sel))) begin
      scale = 16'hffff;
    end else begin
      scale = wide[`SDC_RESULT_W-1:0];
    end
  endfunction : scale

  // ----------------------------------------------------------------------
  // Bit stream synchroniser and decimation
  // ----------------------------------------------------------------------
  logic mod_s1_ff, mod_s2_ff;
  sdc_count_t ones;
  logic done;
  sdc_state_e state_ff, nxt_state;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mod_s1_ff <= 1'b0;
      mod_s2_ff <= 1'b0;
    end else if (clk_en) begin
      mod_s1_ff <= mod_bit;
      mod_s2_ff <= mod_s1_ff;
    end
  end

  sdc_decim u_decim (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .run(state_ff == SDC_RUN),
    .osr_sel(osr_select),
    .bit_in(mod_s2_ff),
    .ones_ff(ones),
    .done_ff(done)
  );

  // ----------------------------------------------------------------------
  // Static analog controls
  // ----------------------------------------------------------------------
  logic nxt_ref_on, nxt_ref_oe, nxt_ext_ref, nxt_bl, nxt_bm, nxt_bh;
  logic [7:0] nxt_disc;

  always_comb begin
    nxt_ref_on = reference_enable;
    nxt_ref_oe = reference_output_buffer_enable;
    nxt_ext_ref = !reference_enable && !reference_output_buffer_enable;
    nxt_disc = analog_pin_enable;
    nxt_bl = (buffer_speed_select == `SDC_BUF_LOW);
    nxt_bm = (buffer_speed_select == `SDC_BUF_MED);
    nxt_bh = (buffer_speed_select == `SDC_BUF_HIGH);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ref_gen_on_ff <= 1'b0;
      ref_pin_drive_oe_ff <= 1'b0;
      ext_ref_accept_ff <= 1'b1;
      digital_disconnect_ff <= `SDC_RST_PINS;
      buf_low_ff <= 1'b0;
      buf_med_ff <= 1'b0;
      buf_high_ff <= 1'b0;
    end else if (clk_en) begin
      ref_gen_on_ff <= nxt_ref_on;
      ref_pin_drive_oe_ff <= nxt_ref_oe;
      ext_ref_accept_ff <= nxt_ext_ref;
      digital_disconnect_ff <= nxt_disc;
      buf_low_ff <= nxt_bl;
      buf_med_ff <= nxt_bm;
      buf_high_ff <= nxt_bh;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------------
  sdc_src_e nxt_src;
  logic [2:0] nxt_chan, nxt_gain;
  logic [1:0] cnt_ff, nxt_cnt, skip;
  logic nxt_flag, nxt_irq, withheld;
  sdc_result_t nxt_result, scaled;

  always_comb begin
    skip = delay_skip(interrupt_delay);
    withheld = cnt_ff < skip;
    scaled = scale(ones, osr_select);
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_src = applied_src_ff;
    nxt_chan = applied_chan_ff;
    nxt_gain = applied_gain_ff;
    nxt_result = result_register;
    nxt_irq = 1'b0;
    nxt_flag = conversion_done_flag;
    if (result_read || flag_clear) begin
      nxt_flag = 1'b0;
    end
    // Idle follows settings at once; a running conversion takes them at a decimation step.
    if (state_ff == SDC_IDLE || done) begin
      nxt_src = chan_src(input_channel_select);
      nxt_chan = input_channel_select;
      nxt_gain = (gain_select > `SDC_GAIN_MAX) ? `SDC_GAIN_MAX : gain_select;
    end
    unique case (state_ff)
      SDC_IDLE: begin
        if (start_set && !start_clear) begin
          nxt_state = SDC_RUN;
          nxt_cnt = '0;
        end
      end
      SDC_RUN: begin
        if (start_clear) begin
          nxt_state = SDC_IDLE;
        end else begin
          if (done) begin
            nxt_result = scaled;
            nxt_flag = 1'b1;
            if (withheld) begin
              nxt_cnt = cnt_ff + 2'h1;
            end else begin
              nxt_irq = 1'b1;
              if (single_mode && !start_set) begin
                nxt_state = SDC_IDLE;
              end
            end
          end
          // Results after a channel or gain change need settling time.
          if (chan_gain_write) begin
            nxt_cnt = '0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= SDC_IDLE;
      cnt_ff <= '0;
      applied_src_ff <= SDC_SRC_EXT;
      applied_chan_ff <= `SDC_RST_CHAN;
      applied_gain_ff <= `SDC_RST_GAIN;
      result_register <= `SDC_RST_RESULT;
      conversion_done_flag <= 1'b0;
      conv_irq_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      applied_src_ff <= nxt_src;
      applied_chan_ff <= nxt_chan;
      applied_gain_ff <= nxt_gain;
      result_register <= nxt_result;
      conversion_done_flag <= nxt_flag;
      conv_irq_ff <= nxt_irq;
    end
  end

  assign converter_power_on = (state_ff == SDC_RUN);
  assign start_conversion_bit = (state_ff == SDC_RUN);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence seq_start;
    clk_en && state_ff == SDC_IDLE && start_set && !start_clear;
  endsequence

  chk_ref_follows: assert property ($changed(ref_gen_on_ff) |-> ref_gen_on_ff == $past(reference_enable))
    else $error("reference changed without its enable");
  chk_ref_kept: assert property ($fell(converter_power_on) && $past(reference_enable) |-> ref_gen_on_ff)
    else $error("reference dropped at power-down");
  chk_pin_drive: assert property (clk_en && reference_output_buffer_enable |=> ref_pin_drive_oe_ff)
    else $error("reference pin not driven");
  chk_ext_excl: assert property (ext_ref_accept_ff |-> !ref_pin_drive_oe_ff && !ref_gen_on_ff)
    else $error("external reference accepted while internal active");
  chk_start_power: assert property (seq_start |=> converter_power_on ##0 cnt_ff == 2'h0)
    else $error("start did not power the converter");
  chk_apply_step: assert property (clk_en && state_ff == SDC_RUN && !done
    |=> $stable(applied_chan_ff) && $stable(applied_gain_ff))
    else $error("channel applied between decimation steps");
  chk_flag_set: assert property (clk_en && state_ff == SDC_RUN && done && !start_clear
    |=> conversion_done_flag && result_register == $past(scaled))
    else $error("result or done flag not updated");
  chk_irq_delay: assert property (conv_irq_ff |-> $past(cnt_ff) >= $past(skip))
    else $error("interrupt request not withheld");
  chk_single_stop: assert property (clk_en && state_ff == SDC_RUN && done && !withheld && single_mode
    && !start_set && !start_clear |=> !start_conversion_bit)
    else $error("single conversion did not clear start bit");
  chk_restart_cnt: assert property (clk_en && state_ff == SDC_RUN && chan_gain_write && !start_clear
    |=> cnt_ff == 2'h0)
    else $error("change did not restart delay count");

endmodule : sdc_ctrl

`default_nettype wire

// File: bench/sdc_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module sdc_src_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Input shape and reference pin state
  input wire logic [1:0] mode,
  input wire logic ref_pin_drive_oe_ff,
  input wire logic ext_ref_accept_ff,
  // Modulator bit and off-chip reference drive
  output logic mod_bit,
  output logic ext_ref_oe
);
  logic [1:0] phase_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Mode 0 is all zeros, 1 all ones, 2 half density and 3 quarter density.
  always_comb begin
    case (mode)
      2'h0: mod_bit = 1'b0;
      2'h1: mod_bit = 1'b1;
      2'h2: mod_bit = phase_ff[0];
      default: mod_bit = (phase_ff == 2'h0);
    endcase
  end

  // The off-chip source only drives the pin while the device accepts it.
  assign ext_ref_oe = ext_ref_accept_ff && !ref_pin_drive_oe_ff;
endmodule : sdc_src_model

`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench import sdc_pkg::*; ();
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic reference_enable = 1'b0;
  logic reference_output_buffer_enable = 1'b0;
  logic [2:0] input_channel_select = 3'h0;
  logic [2:0] gain_select = 3'h0;
  logic [7:0] analog_pin_enable = 8'h00;
  logic [1:0] interrupt_delay = 2'h0;
  logic [1:0] buffer_speed_select = 2'h0;
  logic [2:0] osr_select = 3'h0;
  logic single_mode = 1'b0;
  logic start_set = 1'b0;
  logic start_clear = 1'b0;
  logic chan_gain_write = 1'b0;
  logic result_read = 1'b0;
  logic flag_clear = 1'b0;
  logic [1:0] src_mode = 2'h1;
  logic mod_bit, ext_ref_oe, ref_gen_on_ff, ref_pin_drive_oe_ff, ext_ref_accept_ff;
  logic buf_low_ff, buf_med_ff, buf_high_ff, converter_power_on, start_conversion_bit;
  logic conversion_done_flag, conv_irq_ff, irq;
  logic [7:0] digital_disconnect_ff;
  logic [2:0] applied_chan_ff, applied_gain_ff;
  sdc_src_e applied_src_ff;
  sdc_result_t result_register;
  logic [31:0] rng = 32'h0000_0012;
  int err_count = 0;
  int tests_run = 0;
  int n;

  sdc_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reference_enable(reference_enable),
    .reference_output_buffer_enable(reference_output_buffer_enable), .input_channel_select(input_channel_select),
    .gain_select(gain_select), .analog_pin_enable(analog_pin_enable), .interrupt_delay(interrupt_delay),
    .buffer_speed_select(buffer_speed_select), .osr_select(osr_select), .single_mode(single_mode),
    .start_set(start_set), .start_clear(start_clear), .chan_gain_write(chan_gain_write),
    .result_read(result_read), .flag_clear(flag_clear), .mod_bit(mod_bit), .ref_gen_on_ff(ref_gen_on_ff),
    .ref_pin_drive_oe_ff(ref_pin_drive_oe_ff), .ext_ref_accept_ff(ext_ref_accept_ff),
    .digital_disconnect_ff(digital_disconnect_ff), .buf_low_ff(buf_low_ff), .buf_med_ff(buf_med_ff),
    .buf_high_ff(buf_high_ff), .converter_power_on(converter_power_on), .applied_src_ff(applied_src_ff),
    .applied_chan_ff(applied_chan_ff), .applied_gain_ff(applied_gain_ff),
    .start_conversion_bit(start_conversion_bit), .conversion_done_flag(conversion_done_flag),
    .result_register(result_register), .conv_irq_ff(conv_irq_ff));

  sdc_src_model model (.ref_clk(ref_clk), .resetn(resetn), .mode(src_mode),
    .ref_pin_drive_oe_ff(ref_pin_drive_oe_ff), .ext_ref_accept_ff(ext_ref_accept_ff),
    .mod_bit(mod_bit), .ext_ref_oe(ext_ref_oe));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs

  function automatic sdc_src_e exp_src(input logic [2:0] c);
    exp_src = (c <= 3'h4) ? SDC_SRC_EXT : sdc_src_e'(c - 3'h4);
  endfunction : exp_src

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic strobe(input bit stop);
    @(posedge ref_clk);
    if (stop) start_clear <= 1'b1;
    else start_set <= 1'b1;
    @(posedge ref_clk);
    start_clear <= 1'b0;
    start_set <= 1'b0;
    #1;
    chk("power", 16'(!stop), 16'(converter_power_on));
  endtask : strobe

  // Waits for a result, keeps its request bit, then clears the flag by read or by clear.
  task automatic wait_result(input bit by_read, output logic got_irq, output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end while (conversion_done_flag !== 1'b1 && cyc < 3000);
    chk("result wait", 16'h0000, 16'(cyc >= 3000));
    got_irq = conv_irq_ff;
    @(posedge ref_clk);
    if (by_read) result_read <= 1'b1;
    else flag_clear <= 1'b1;
    @(posedge ref_clk);
    result_read <= 1'b0;
    flag_clear <= 1'b0;
    #1;
    chk("flag clear", 16'h0000, 16'(conversion_done_flag));
  endtask : wait_result

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    #240000;
    err_count++;
    test_done();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    chk("reset accept", 16'h0001, 16'(ext_ref_accept_ff));
    chk("reset power", 16'h0000, 16'(converter_power_on));
    resetn <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      rng = xs(rng);
      @(posedge ref_clk);
      reference_enable <= rng[0];
      reference_output_buffer_enable <= rng[1];
      analog_pin_enable <= rng[15:8];
      buffer_speed_select <= rng[5:4];
      @(posedge ref_clk);
      #1;
      chk("ref gen", 16'(rng[0]), 16'(ref_gen_on_ff));
      chk("ref pin", 16'(rng[1]), 16'(ref_pin_drive_oe_ff));
      chk("ext accept", 16'(!rng[0] && !rng[1]), 16'(ext_ref_accept_ff));
      chk("ext drive", 16'(!rng[0] && !rng[1]), 16'(ext_ref_oe));
      chk("disconnect", 16'(rng[15:8]), 16'(digital_disconnect_ff));
      chk("buffer", 16'((rng[5:4] == 2'h0) ? 3'h0 : 3'h1 << (rng[5:4] - 2'h1)),
        16'({buf_high_ff, buf_med_ff, buf_low_ff}));
    end
    // A low clock enable must hold the registered reference state.
    @(posedge ref_clk);
    clk_en <= 1'b0;
    reference_enable <= !rng[0];
    repeat (3) @(posedge ref_clk);
    #1;
    chk("frozen ref", 16'(rng[0]), 16'(ref_gen_on_ff));
    @(posedge ref_clk);
    clk_en <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("thawed ref", 16'(!rng[0]), 16'(ref_gen_on_ff));
    for (int c = 0; c < 8; c++) begin
      @(posedge ref_clk);
      input_channel_select <= 3'(c);
      gain_select <= 3'(c);
      @(posedge ref_clk);
      #1;
      chk("chan", 16'(c), 16'(applied_chan_ff));
      chk("source", 16'(exp_src(3'(c))), 16'(applied_src_ff));
      chk("gain", 16'((c > 5) ? 5 : c), 16'(applied_gain_ff));
    end
    reference_enable <= 1'b1;
    single_mode <= 1'b1;
    strobe(1'b0);
    for (int k = 0; k < 4; k++) begin
      wait_result(k[0], irq, n);
      chk("single irq", 16'(k == 3), 16'(irq));
      chk("full scale", 16'hffff, result_register);
    end
    chk("start bit", 16'h0000, 16'(start_conversion_bit));
    chk("idle power", 16'h0000, 16'(converter_power_on));
    chk("ref kept", 16'h0001, 16'(ref_gen_on_ff));
    single_mode <= 1'b0;
    interrupt_delay <= 2'h1;
    osr_select <= 3'h1;
    src_mode <= 2'h2;
    strobe(1'b0);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) begin
        @(posedge ref_clk);
        input_channel_select <= 3'h6;
        chan_gain_write <= 1'b1;
        @(posedge ref_clk);
        chan_gain_write <= 1'b0;
        #1;
        chk("chan held", 16'h0007, 16'(applied_chan_ff));
      end
      wait_result(k[0], irq, n);
      chk("delay irq", 16'(k == 2 || k == 5), 16'(irq));
      chk("half scale", 16'h8000, result_register);
      chk("chan", 16'((k < 3) ? 7 : 6), 16'(applied_chan_ff));
    end
    strobe(1'b1);
    interrupt_delay <= 2'h3;
    src_mode <= 2'h3;
    for (int c = 0; c < 8; c++) begin
      osr_select <= 3'(c);
      strobe(1'b0);
      wait_result(1'b0, irq, n);
      wait_result(1'b1, irq, n);
      chk("period", 16'((32 << ((c > 5) ? 5 : c)) - 2), 16'(n));
      chk("every irq", 16'h0001, 16'(irq));
      chk("quarter", 16'h4000, result_register);
      chk("running", 16'h0001, 16'(start_conversion_bit));
      strobe(1'b1);
    end
    test_done();
  end
endmodule : testbench

`default_nettype wire
